// ---- verilog/pwm_interrupt_enable_logic.sv ----
// Interrupt enable logic of the pulse-width-modulation unit.
// Assumes APB at pclk, event pulses one cycle wide on pclk.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module pwm_interrupt_enable_logic
  import irq_enable_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire event_vec_t events_in,
  output logic [6:0] irq_gated,
  output logic irq
);
  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  apb_req_t req;
  logic wr_stb;
  logic rd_stb;
  logic [11:0] addr;
  logic [31:0] wdata;
  apb_phase_t phase;
  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  apb_decode u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .req(req),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr),
    .wdata(wdata),
    .phase(phase)
  );

  logic hit_mask;
  logic hit_set;
  logic hit_stat;
  logic hit_smask;
  logic mapped;
  assign hit_mask = (addr == OFS_INTERRUPT_MASK);
  assign hit_set = (addr == OFS_INTERRUPT_MASK_SET);
  assign hit_stat = (addr == OFS_EVENT_STATUS);
  assign hit_smask = (addr == OFS_EVENT_STATUS_MASK);
  assign mapped = hit_mask | hit_set | hit_stat | hit_smask;
  // Writes land once, at the edge that completes the access; a W1C clear
  // still drops an event on a written-one bit latched during the wait cycle
  logic wr_go;
  assign wr_go = wr_stb && pready;

  // ---------------------------------------------------------------
  // Enable storage shared by the mask and set registers
  // ---------------------------------------------------------------
  logic [6:0] enable_ff;
  logic [6:0] nxt_enable;
  always_comb begin
    nxt_enable = enable_ff;
    if (wr_go && hit_mask) begin
      nxt_enable = from_word(wdata);
    end else if (wr_go && hit_set) begin
      // Zeros leave fields alone so tasks can own separate bits
      nxt_enable = enable_ff | from_word(wdata);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= from_word(RST_INTERRUPT_MASK);
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // ---------------------------------------------------------------
  // Sticky status and its mask
  // ---------------------------------------------------------------
  logic [6:0] status;
  logic [6:0] smask_ff;
  event_status #(.WIDTH(NUM_EVENTS)) u_stat (
    .pclk(pclk),
    .presetn(presetn),
    .evt(events_in & enable_ff),
    .clr_stb(wr_go && hit_stat),
    .clr_bits(from_word(wdata)),
    .status(status)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smask_ff <= RST_STATUS_MASK;
    end else if (wr_go && hit_smask) begin
      smask_ff <= from_word(wdata);
    end
  end

  // ---------------------------------------------------------------
  // Interrupt outputs, registered
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_gated <= 7'h00;
      irq <= 1'b0;
    end else begin
      irq_gated <= status & smask_ff;
      irq <= |(status & smask_ff);
    end
  end

  // ---------------------------------------------------------------
  // Read data and bus answer, registered; one wait cycle per access
  // ---------------------------------------------------------------
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (hit_mask || hit_set) begin
      nxt_rdata = to_word(enable_ff);
    end else if (hit_stat) begin
      nxt_rdata = to_word(status);
    end else if (hit_smask) begin
      nxt_rdata = to_word(smask_ff);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (rd_stb && !pready) begin
        prdata <= nxt_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Writes land only at the completing edge, so every register write,
  // and every W1C clear above all, takes effect exactly once.
  property p_reset_zero;
    @(posedge pclk) $rose(presetn) |-> enable_ff == 7'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("enables not zero after reset");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
    wr_go && hit_mask |=> enable_ff == $past(pwdata[7:1]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_stop_gate;
    @(posedge pclk) disable iff (!presetn)
    events_in.stopped_event && !enable_ff[0] && !status[0]
      && !(wr_go && hit_stat) |=> !status[0];
  endproperty
  a_stop_gate: assert property (p_stop_gate)
    else $error("masked stopped event latched");

  property p_begun_pass;
    @(posedge pclk) disable iff (!presetn)
    events_in.sequence_begun_event1 && enable_ff[2] |=> status[2];
  endproperty
  a_begun_pass: assert property (p_begun_pass)
    else $error("sequence begun event lost");

  property p_finished_block;
    @(posedge pclk) disable iff (!presetn)
    !status[3] && !(events_in.sequence_finished_event0 && enable_ff[3])
      |=> !status[3];
  endproperty
  a_finished_block: assert property (p_finished_block)
    else $error("sequence finished set without cause");

  property p_period_pass;
    @(posedge pclk) disable iff (!presetn)
    events_in.period_end_event && enable_ff[5] |=> status[5];
  endproperty
  a_period_pass: assert property (p_period_pass)
    else $error("period end event lost");

  property p_set_unmask;
    @(posedge pclk) disable iff (!presetn)
    wr_go && hit_set && pwdata[POS_REPEAT_COUNT_COMPLETE] |=> enable_ff[6];
  endproperty
  a_set_unmask: assert property (p_set_unmask)
    else $error("set write did not unmask");

  property p_set_keeps;
    @(posedge pclk) disable iff (!presetn)
    wr_go && hit_set |=> (enable_ff & $past(enable_ff)) == $past(enable_ff);
  endproperty
  a_set_keeps: assert property (p_set_keeps)
    else $error("set write cleared a field");

  property p_read_set;
    @(posedge pclk) disable iff (!presetn)
    rd_stb && hit_set && !pready |=> prdata == to_word($past(enable_ff));
  endproperty
  a_read_set: assert property (p_read_set)
    else $error("set register read wrong");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    ##1 irq == |$past(status & smask_ff);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level wrong");

  // ---------------------------------------------------------------
  // Assertions: remaining fields, read path and bus answer
  // ---------------------------------------------------------------
  property p_stop_pass;
    @(posedge pclk) disable iff (!presetn)
    events_in.stopped_event && enable_ff[0] |=> status[0];
  endproperty
  a_stop_pass: assert property (p_stop_pass)
    else $error("stopped event lost");

  property p_begun0_pass;
    @(posedge pclk) disable iff (!presetn)
    events_in.sequence_begun_event0 && enable_ff[1] |=> status[1];
  endproperty
  a_begun0_pass: assert property (p_begun0_pass)
    else $error("first sequence begun event lost");

  property p_begun0_block;
    @(posedge pclk) disable iff (!presetn)
    !status[1] && !(events_in.sequence_begun_event0 && enable_ff[1])
      |=> !status[1];
  endproperty
  a_begun0_block: assert property (p_begun0_block)
    else $error("sequence begun set without cause");

  property p_finished0_pass;
    @(posedge pclk) disable iff (!presetn)
    events_in.sequence_finished_event0 && enable_ff[3] |=> status[3];
  endproperty
  a_finished0_pass: assert property (p_finished0_pass)
    else $error("first sequence finished event lost");

  property p_finished1_pass;
    @(posedge pclk) disable iff (!presetn)
    events_in.sequence_finished_event1 && enable_ff[4] |=> status[4];
  endproperty
  a_finished1_pass: assert property (p_finished1_pass)
    else $error("second sequence finished event lost");

  property p_period_block;
    @(posedge pclk) disable iff (!presetn)
    !status[5] && !(events_in.period_end_event && enable_ff[5])
      |=> !status[5];
  endproperty
  a_period_block: assert property (p_period_block)
    else $error("period end set without cause");

  property p_repeat_pass;
    @(posedge pclk) disable iff (!presetn)
    events_in.repeat_count_complete_event && enable_ff[6] |=> status[6];
  endproperty
  a_repeat_pass: assert property (p_repeat_pass)
    else $error("repeat complete event lost");

  property p_enable_hold;
    @(posedge pclk) disable iff (!presetn)
    !(wr_go && (hit_mask || hit_set)) |=> $stable(enable_ff);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("enables changed without a write");

  property p_set_zero_noop;
    @(posedge pclk) disable iff (!presetn)
    wr_go && hit_set && pwdata[7:1] == 7'h00 |=> $stable(enable_ff);
  endproperty
  a_set_zero_noop: assert property (p_set_zero_noop)
    else $error("zero set write changed enables");

  property p_read_mask;
    @(posedge pclk) disable iff (!presetn)
    rd_stb && hit_mask && !pready |=> prdata == to_word($past(enable_ff));
  endproperty
  a_read_mask: assert property (p_read_mask)
    else $error("mask register read wrong");

  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite |-> prdata[31:8] == 24'h000000 && !prdata[0];
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused read bits not zero");

  property p_gated_level;
    @(posedge pclk) disable iff (!presetn)
    ##1 irq_gated == $past(status & smask_ff);
  endproperty
  a_gated_level: assert property (p_gated_level)
    else $error("gated interrupt vector wrong");

  property p_ready_after_wait;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_after_wait: assert property (p_ready_after_wait)
    else $error("no answer after one wait cycle");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");

  property p_slverr_with_ready;
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready;
  endproperty
  a_slverr_with_ready: assert property (p_slverr_with_ready)
    else $error("error answer without ready");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !mapped |=> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not refused");

  c_set_write: cover property (@(posedge pclk) wr_stb && hit_set);
  c_mask_read: cover property (@(posedge pclk) rd_stb && hit_mask);
  c_irq: cover property (@(posedge pclk) $rose(irq));
  c_err: cover property (@(posedge pclk) pslverr && pready);
  c_access: cover property (@(posedge pclk) phase == APB_ACCESS);
endmodule
`default_nettype wire

// ---- verilog/irq_enable_pkg.sv ----
// Package: offsets, field layout, reset values and carriers of the
// interrupt enable logic.
// Assumes a 32-bit APB register bus.
package irq_enable_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int NUM_EVENTS = 7;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_INTERRUPT_MASK = 12'h300;
  localparam logic [11:0] OFS_INTERRUPT_MASK_SET = 12'h304;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h310;
  localparam logic [11:0] OFS_EVENT_STATUS_MASK = 12'h314;
  localparam logic [31:0] RST_INTERRUPT_MASK = 32'h00000000;
  localparam logic [6:0] RST_STATUS = 7'h00;
  localparam logic [6:0] RST_STATUS_MASK = 7'h00;
  // ---------------------------------------------------------------
  // Field layout: seven enables in bits 1..7, in event order
  // ---------------------------------------------------------------
  localparam int FLD_LSB = 1;
  localparam int POS_STOPPED = 1;
  localparam int POS_SEQUENCE_BEGUN0 = 2;
  localparam int POS_SEQUENCE_BEGUN1 = 3;
  localparam int POS_SEQUENCE_FINISHED0 = 4;
  localparam int POS_SEQUENCE_FINISHED1 = 5;
  localparam int POS_PERIOD_END = 6;
  localparam int POS_REPEAT_COUNT_COMPLETE = 7;

  typedef struct packed {
    logic repeat_count_complete_event;
    logic period_end_event;
    logic sequence_finished_event1;
    logic sequence_finished_event0;
    logic sequence_begun_event1;
    logic sequence_begun_event0;
    logic stopped_event;
  } event_vec_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_SETUP = 2'b01,
    APB_ACCESS = 2'b11
  } apb_phase_t;

  function automatic logic [31:0] to_word(input logic [6:0] f);
    to_word = {24'h000000, f, 1'b0};
  endfunction

  function automatic logic [6:0] from_word(input logic [31:0] w);
    from_word = w[7:1];
  endfunction
endpackage

// ---- verilog/apb_decode.sv ----
// APB slave front end: decodes one access per setup/access pair.
// Assumes an APB master per the usual two-phase protocol.
`timescale 1ns/1ns
`default_nettype none
module apb_decode
  import irq_enable_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t req,
  output logic wr_stb,
  output logic rd_stb,
  output logic [11:0] addr,
  output logic [31:0] wdata,
  output var apb_phase_t phase
);
  // -----------------------------------------------------------------
  // Phase tracker, for cover and debug only
  // -----------------------------------------------------------------
  apb_phase_t phase_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= APB_IDLE;
    end else if (req.psel && !req.penable) begin
      phase_ff <= APB_SETUP;
    end else if (req.psel && req.penable) begin
      phase_ff <= APB_ACCESS;
    end else begin
      phase_ff <= APB_IDLE;
    end
  end
  assign phase = phase_ff;
  // Strobes follow every access cycle; completion waits for pready, one wait cycle later
  assign wr_stb = req.psel && req.penable && req.pwrite;
  assign rd_stb = req.psel && req.penable && !req.pwrite;
  assign addr = req.paddr;
  assign wdata = req.pwdata;
endmodule
`default_nettype wire

// ---- verilog/event_status.sv ----
// Sticky event flags, write-one-to-clear, set wins over clear.
// Assumes one-cycle event pulses synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module event_status
  import irq_enable_pkg::*;
#(
  parameter int WIDTH = NUM_EVENTS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] evt,
  input wire logic clr_stb,
  input wire logic [WIDTH-1:0] clr_bits,
  output logic [WIDTH-1:0] status
);
  // Elaboration-time guard: the reset constant is sized for the event count
  if (WIDTH != NUM_EVENTS) begin : g_width_check
    $error("event_status width must equal event count");
  end
  logic [WIDTH-1:0] status_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= RST_STATUS;
    end else begin
      // A pulse in the clearing cycle is kept
      status_ff <= (status_ff & ~(clr_stb ? clr_bits : '0)) | evt;
    end
  end
  assign status = status_ff;
endmodule
`default_nettype wire

// ---- bench/event_source.sv ----
// Event source model: stands in for the waveform engine raising events.
// Assumes the bench calls fire from one process only.
`timescale 1ns/1ns
`default_nettype none
module event_source
  import irq_enable_pkg::*;
(
  input wire logic pclk,
  output var event_vec_t events_out
);
  initial events_out = '0;
  // One-cycle pulse, launched just after a rising edge
  task automatic fire(input logic [6:0] v);
    @(posedge pclk);
    events_out <= event_vec_t'(v);
    @(posedge pclk);
    events_out <= '0;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Testbench of the interrupt enable logic: APB master tasks, event model.
// Assumes one wait state per access, but waits under a bound regardless.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import irq_enable_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] irq_gated;
  event_vec_t events;
  int num_errors, check_count;

  pwm_interrupt_enable_logic DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events_in(events), .irq_gated(irq_gated), .irq(irq));
  event_source src (.pclk(pclk), .events_out(events));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge pclk);
    check({31'h00000000, irq}, {31'h00000000, exp});
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    num_errors = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFS_INTERRUPT_MASK, RST_INTERRUPT_MASK);
    rd_chk(OFS_INTERRUPT_MASK_SET, 32'h00000000);
    check({31'h00000000, er}, 32'h00000000);
    irq_chk(1'b0);
    apb(1'b1, OFS_INTERRUPT_MASK, 32'hFFFFFFFF);
    rd_chk(OFS_INTERRUPT_MASK, 32'h000000FE);
    rd_chk(OFS_INTERRUPT_MASK_SET, 32'h000000FE);
    apb(1'b1, OFS_INTERRUPT_MASK, 32'h0000000A);
    rd_chk(OFS_INTERRUPT_MASK, 32'h0000000A);
    // Zero through the set register must leave every enable alone
    apb(1'b1, OFS_INTERRUPT_MASK_SET, 32'h00000000);
    rd_chk(OFS_INTERRUPT_MASK, 32'h0000000A);
    apb(1'b1, OFS_INTERRUPT_MASK_SET, 32'h00000080);
    rd_chk(OFS_INTERRUPT_MASK_SET, 32'h0000008A);
    apb(1'b1, 12'h308, 32'hFFFFFFFF);
    check({31'h00000000, er}, 32'h00000001);
    rd_chk(12'h308, 32'h00000000);
    check({31'h00000000, er}, 32'h00000001);
    rd_chk(OFS_INTERRUPT_MASK, 32'h0000008A);
    // All events fire at once; only the one enabled field may latch
    apb(1'b1, OFS_EVENT_STATUS_MASK, 32'h000000FE);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, OFS_INTERRUPT_MASK, 32'h00000002 << i);
      src.fire(7'h7F);
      irq_chk(1'b1);
      check({25'h0000000, irq_gated}, 32'h00000001 << i);
      rd_chk(OFS_EVENT_STATUS, 32'h00000002 << i);
      apb(1'b1, OFS_EVENT_STATUS, 32'h000000FE);
      irq_chk(1'b0);
    end
    apb(1'b1, OFS_INTERRUPT_MASK, 32'h00000000);
    src.fire(7'h7F);
    rd_chk(OFS_EVENT_STATUS, 32'h00000000);
    // Status mask holds the line low until it is opened
    apb(1'b1, OFS_INTERRUPT_MASK_SET, 32'h000000FE);
    apb(1'b1, OFS_EVENT_STATUS_MASK, 32'h00000000);
    src.fire(7'h7F);
    irq_chk(1'b0);
    rd_chk(OFS_EVENT_STATUS, 32'h000000FE);
    apb(1'b1, OFS_EVENT_STATUS_MASK, 32'h00000010);
    irq_chk(1'b1);
    apb(1'b1, OFS_EVENT_STATUS, 32'h00000010);
    irq_chk(1'b0);
    // Mid-run reset must drop every enable again
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFS_INTERRUPT_MASK, RST_INTERRUPT_MASK);
    tally_and_finish();
  end
endmodule
`default_nettype wire
